// ---- core/vfl_top.sv ----
// Vertical filter: seven line stores, 8-tap FIR, round, window and clamp
//
// Implementation choices: the plain strobed port and the placing of the registers.
module vfl_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire vfl_pkg::vfl_bus_req_t bus_req,
    output logic [31:0] rd_data,
    // Pixel stream
    input wire vfl_pkg::vfl_pix_in_t pix_in,
    output vfl_pkg::vfl_pix_out_t pix_out
);
    import vfl_pkg::*;

    typedef struct packed {
        logic [11:0] line_length_setting;
        logic [11:0] line_store_control;
        logic [11:0] filter_mode;
        logic [11:0] clamp_enable_control;
        logic [TAPS-1:0][DATA_W-1:0] coef;
        logic [SETS-1:0][SEL_W-1:0] vsel;
        logic [SETS-1:0][ACC_W-1:0] vrnd;
        logic [SETS-1:0][LIM_W-1:0] vlim;
        logic [ADDR_W-1:0] ptr;
        logic [DATA_W-1:0] in_word;
        logic [3:0] in_idx;
        logic in_vld;
        logic [ACC_W-1:0] acc;
        logic [3:0] acc_idx;
        logic acc_vld;
        logic [DATA_W-1:0] out_word;
        logic out_vld;
        logic [31:0] rd_data;
    } vfl_state_t;

    vfl_state_t s_q, s_d;

    logic [NBUF-1:0][DATA_W-1:0] buf_rd;
    logic [NBUF-1:0][DATA_W-1:0] buf_wr;
    logic shift_en;
    logic in_load;
    logic [ADDR_W-1:0] ring_last;

    // Pick a 12-bit window starting at bit pos of the signed result
    function automatic logic [DATA_W-1:0] win_pick(logic [ACC_W-1:0] v, logic [SEL_W-1:0] pos);
        logic signed [ACC_W-1:0] t;
        t = $signed(v) >>> pos;
        return t[DATA_W-1:0];
    endfunction

    // Signed less-than on two 12-bit words
    function automatic logic lt_s(logic [DATA_W-1:0] a, logic [DATA_W-1:0] b);
        return $signed(a) < $signed(b);
    endfunction

    // Test whether an address falls in a sixteen-entry block
    function automatic logic in_block(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] base);
        return a[ADDR_W-1:4] == base[ADDR_W-1:4];
    endfunction

    // Loading gates by filter mode
    always_comb begin
        if (s_q.filter_mode[MODE_SEP_BIT]) begin // [RULE21]
            in_load = 1'b1;
            shift_en = pix_in.vertical_shift_gate; // [RULE8]
        end else begin
            in_load = pix_in.vertical_shift_gate & pix_in.horizontal_shift_gate; // [RULE9]
            shift_en = in_load; // [RULE9]
        end
    end

    // Ring spans setting plus 3 slots; the registered read adds the fourth cycle
    assign ring_last = s_q.line_length_setting + LEN_EXTRA - 12'h002; // [RULE3] [RULE10]

    // Data fed into each line store; recirculate wins over parallel load
    always_comb begin
        for (int i = 0; i < NBUF; i++) begin
            if (s_q.line_store_control[STORE_RECIRC_BIT]) begin
                buf_wr[i] = buf_rd[i]; // [RULE6] [RULE19]
            end else if (s_q.line_store_control[STORE_PAR_BIT] || i == 0) begin
                buf_wr[i] = s_q.in_word; // [RULE7]
            end else begin
                buf_wr[i] = buf_rd[i-1]; // [RULE5]
            end
        end
    end

    // Seven line stores sharing one ring pointer
    for (genvar g = 0; g < NBUF; g++) begin : g_buf
        vfl_line_mem u_mem ( // [RULE2]
            .clk(clk),
            .en(shift_en),
            .we(1'b1),
            .addr(s_q.ptr),
            .wdata(buf_wr[g]),
            .rdata(buf_rd[g])
        );
    end

    // Next state
    always_comb begin
        logic [ACC_W-1:0] sum;
        logic [DATA_W-1:0] win;
        logic [DATA_W-1:0] lo;
        logic [DATA_W-1:0] hi;
        logic [3:0] ix;
        logic [ADDR_W-1:0] a;
        sum = '0;
        win = '0;
        lo = '0;
        hi = '0;
        ix = bus_req.addr[3:0];
        a = bus_req.addr;
        s_d = s_q;

        // Register writes
        if (bus_req.wr) begin
            if (a == A_LEN) begin
                s_d.line_length_setting = bus_req.wdata[11:0];
            end
            if (a == A_STORE) begin
                s_d.line_store_control = bus_req.wdata[11:0];
            end
            if (a == A_MODE) begin
                s_d.filter_mode = bus_req.wdata[11:0];
            end
            if (a == A_CLAMP) begin
                s_d.clamp_enable_control = bus_req.wdata[11:0];
            end
            if (in_block(a, A_COEF_BASE) && ix < 4'(TAPS)) begin
                s_d.coef[ix[2:0]] = bus_req.wdata[DATA_W-1:0];
            end
            if (in_block(a, A_VSEL_BASE)) begin
                s_d.vsel[ix] = bus_req.wdata[SEL_W-1:0];
            end
            if (in_block(a, A_VRND_BASE)) begin
                s_d.vrnd[ix] = bus_req.wdata;
            end
            if (in_block(a, A_VLIM_BASE)) begin
                s_d.vlim[ix] = bus_req.wdata[LIM_W-1:0];
            end
        end

        // Register reads: data stand for one cycle only, unmapped reads zero
        s_d.rd_data = '0;
        if (bus_req.rd) begin
            if (a == A_LEN) begin
                s_d.rd_data = {20'h00000, s_q.line_length_setting};
            end else if (a == A_STORE) begin
                s_d.rd_data = {20'h00000, s_q.line_store_control};
            end else if (a == A_MODE) begin
                s_d.rd_data = {20'h00000, s_q.filter_mode};
            end else if (a == A_CLAMP) begin
                s_d.rd_data = {20'h00000, s_q.clamp_enable_control};
            end else if (a == A_STATUS) begin
                s_d.rd_data = {18'h00000, s_q.out_vld, s_q.in_vld, s_q.ptr};
            end else if (in_block(a, A_COEF_BASE) && ix < 4'(TAPS)) begin
                s_d.rd_data = {20'h00000, s_q.coef[ix[2:0]]};
            end else if (in_block(a, A_VSEL_BASE)) begin
                s_d.rd_data = {27'h0000000, s_q.vsel[ix]};
            end else if (in_block(a, A_VRND_BASE)) begin
                s_d.rd_data = s_q.vrnd[ix];
            end else if (in_block(a, A_VLIM_BASE)) begin
                s_d.rd_data = {8'h00, s_q.vlim[ix]};
            end
        end

        // Ring pointer advances on each shift and wraps to 0 after slot setting plus 2
        if (shift_en) begin
            s_d.ptr = (s_q.ptr >= ring_last) ? 12'h000 : s_q.ptr + 12'h001; // [RULE3]
        end

        // Input register with its set index and load flag
        s_d.in_vld = in_load;
        if (in_load) begin
            s_d.in_word = pix_in.pixel_input_word; // [RULE9]
            s_d.in_idx = pix_in.vertical_set_index; // [RULE12]
        end

        // FIR over the input register and seven delayed lines, plus rounding
        sum = s_q.vrnd[s_q.in_idx]; // [RULE11] [RULE12] [RULE22]
        for (int i = 0; i < TAPS; i++) begin
            if (i == 0) begin
                sum = sum + ACC_W'($signed(s_q.coef[i]) * $signed(s_q.in_word)); // [RULE1]
            end else begin
                sum = sum + ACC_W'($signed(s_q.coef[i]) * $signed(buf_rd[i-1])); // [RULE1] [RULE23]
            end
        end
        s_d.acc = sum;
        s_d.acc_idx = s_q.in_idx; // [RULE22]
        s_d.acc_vld = s_q.in_vld;

        // Window selection then limiting with the same set index
        win = win_pick(s_q.acc, s_q.vsel[s_q.acc_idx]); // [RULE14] [RULE15] [RULE23]
        lo = s_q.vlim[s_q.acc_idx][LIM_LO_LSB +: DATA_W]; // [RULE16]
        hi = s_q.vlim[s_q.acc_idx][LIM_HI_LSB +: DATA_W]; // [RULE16]
        s_d.out_word = win; // [RULE20]
        if (s_q.clamp_enable_control[CLAMP_V_BIT]) begin // [RULE16] [RULE20]
            if (lt_s(win, lo)) begin
                s_d.out_word = lo; // [RULE17]
            end else if (lt_s(hi, win)) begin
                s_d.out_word = hi; // [RULE17]
            end
        end
        s_d.out_vld = s_q.acc_vld;
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.line_length_setting <= RST_LEN;
            s_q.line_store_control <= RST_STORE;
            s_q.filter_mode <= RST_MODE;
            s_q.clamp_enable_control <= RST_CLAMP;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign rd_data = s_q.rd_data;
    assign pix_out.word = s_q.out_word;
    assign pix_out.valid = s_q.out_vld;
endmodule

// ---- common/vfl_pkg.sv ----
// Constants and carrier types for the vertical filter line buffer output path
// Notes on behaviour
// RULE1: Vertical FIR across image lines with up to eight taps.
// RULE2: Seven on-chip line buffers, each one line of delay for the taps.
// RULE3: Buffer delay is the programmed length setting plus 4, so 4 to 3076.
// RULE4: Software never programs a length setting above 3072.
// RULE5: Mode bit picks delay or recirculate; delay mode delays input by length.
// RULE6: Recirculate mode feeds each buffer's output back so contents repeat.
// RULE7: Parallel-load bit makes the input register load all seven buffers at once.
// RULE8: Separate mode: vertical shift gate gates buffer loading, else buffers hold.
// RULE9: Orthogonal mode: input register and buffers load only when both gates are on.
// RULE10: Interleaved lines of any set count work up to 3076 values per line.
// RULE11: Result is rounded by adding one of sixteen 32-bit round registers.
// RULE12: Set index n picks round register n, may change every cycle.
// RULE13: Software selects a zero round register when no rounding is wanted.
// RULE14: A 12-bit window of the 32-bit result, placed by the select register.
// RULE15: Set index n picks select register n, window may change every cycle.
// RULE16: Limiting only when enabled, using one of sixteen 24-bit limit registers.
// RULE17: Values below lower bound become lower, above upper become upper.
// RULE18: Software programs each upper bound above its lower bound.
// RULE19: Mode bit one is recirculate, zero is delay.
// RULE20: Limit enable zero passes the window unchanged, one limits.
// RULE21: Filter mode bit one is dimensionally separate, zero is orthogonal.
// RULE22: Round, then window, then limit, with sets aligned to the same word.
// RULE23: Rounding, windowing and limit compares are signed two's complement.
package vfl_pkg;
    localparam int unsigned DATA_W = 12;
    localparam int unsigned ACC_W = 32;
    localparam int unsigned TAPS = 8;
    localparam int unsigned NBUF = 7;
    localparam int unsigned SETS = 16;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned LIM_W = 24;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DEPTH = 4096;

    // Line length handling
    localparam logic [11:0] LEN_EXTRA = 12'h004;
    localparam logic [11:0] LEN_MAX_SETTING = 12'hC00;

    // Register addresses
    localparam logic [11:0] A_LEN = 12'h202;
    localparam logic [11:0] A_STORE = 12'h203;
    localparam logic [11:0] A_MODE = 12'h204;
    localparam logic [11:0] A_CLAMP = 12'h205;
    localparam logic [11:0] A_STATUS = 12'h206;
    localparam logic [11:0] A_COEF_BASE = 12'h100;
    localparam logic [11:0] A_VSEL_BASE = 12'h600;
    localparam logic [11:0] A_VRND_BASE = 12'hA00;
    localparam logic [11:0] A_VLIM_BASE = 12'hE00;

    // Field positions
    localparam int unsigned STORE_RECIRC_BIT = 0;
    localparam int unsigned STORE_PAR_BIT = 1;
    localparam int unsigned MODE_SEP_BIT = 0;
    localparam int unsigned CLAMP_V_BIT = 0;
    localparam int unsigned LIM_LO_LSB = 0;
    localparam int unsigned LIM_HI_LSB = 12;

    // Values after reset
    localparam logic [11:0] RST_LEN = 12'h000;
    localparam logic [11:0] RST_STORE = 12'h000;
    localparam logic [11:0] RST_MODE = 12'h000;
    localparam logic [11:0] RST_CLAMP = 12'h000;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [ACC_W-1:0] wdata;
    } vfl_bus_req_t;

    // Upstream pixel word with its set index and shift gates
    typedef struct packed {
        logic [DATA_W-1:0] pixel_input_word;
        logic [3:0] vertical_set_index;
        logic horizontal_shift_gate;
        logic vertical_shift_gate;
    } vfl_pix_in_t;

    // Downstream result
    typedef struct packed {
        logic [DATA_W-1:0] word;
        logic valid;
    } vfl_pix_out_t;
endpackage

// ---- core/vfl_line_mem.sv ----
// One line store: single-port RAM, read-before-write, registered read data
module vfl_line_mem
    import vfl_pkg::*;
(
    // Clock
    input wire logic clk,
    // Access
    input wire logic en,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] rdata_q;

    // Old word comes out while the new one goes in; all holds when en is low
    always_ff @(posedge clk) begin
        if (en) begin
            rdata_q <= mem[addr];
            if (we) begin
                mem[addr] <= wdata;
            end
        end
    end

    assign rdata = rdata_q;
endmodule

// ---- verif/vfl_top_chk.sv ----
// Port checker for the vertical filter output path
module vfl_top_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire vfl_pkg::vfl_bus_req_t bus_req,
    input wire logic [31:0] rd_data,
    // Pixel stream
    input wire vfl_pkg::vfl_pix_in_t pix_in,
    input wire vfl_pkg::vfl_pix_out_t pix_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import vfl_pkg::*;
    logic rst_q;
    logic sep_q;
    logic clamp_q;
    logic [3:0] ra_q;
    logic [3:0] i1_q;
    logic [3:0] i2_q;
    logic [3:0] i3_q;
    logic [23:0] lim_q [16];
    wire both_g = pix_in.horizontal_shift_gate & pix_in.vertical_shift_gate;
    wire logic signed [11:0] lo = lim_q[i3_q][11:0];
    wire logic signed [11:0] hi = lim_q[i3_q][23:12];
    // Shadow of written settings and set index carried down the pipe
    always_ff @(posedge clk) begin
        rst_q <= rst;
        ra_q <= bus_req.addr[3:0];
        i1_q <= pix_in.vertical_set_index;
        i2_q <= i1_q;
        i3_q <= i2_q;
        if (rst) begin
            sep_q <= 1'b0;
            clamp_q <= 1'b0;
            for (int n = 0; n < 16; n++) lim_q[n] <= 24'h000000;
        end else if (bus_req.wr) begin
            if (bus_req.addr == A_MODE) sep_q <= bus_req.wdata[MODE_SEP_BIT];
            if (bus_req.addr == A_CLAMP) clamp_q <= bus_req.wdata[CLAMP_V_BIT];
            if (bus_req.addr[11:4] == A_VLIM_BASE[11:4])
                lim_q[bus_req.addr[3:0]] <= bus_req.wdata[23:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    // Pipe is still empty at the edge that releases the synchronous reset
    default disable iff (rst || rst_q);
    AST_ORTHO_BLOCK: assert property (!sep_q && !both_g |-> ##3 !pix_out.valid)
        else $error("word loaded with a gate off");
    AST_ORTHO_PASS: assert property (!sep_q && both_g |-> ##3 pix_out.valid)
        else $error("word not loaded with both gates on");
    AST_SEP_LOAD: assert property (sep_q |-> ##3 pix_out.valid)
        else $error("separate mode word not loaded");
    AST_CLAMP_LO: assert property (pix_out.valid && clamp_q && $past(clamp_q, 3)
        |-> $signed(pix_out.word) >= lo) else $error("output below lower bound");
    AST_CLAMP_HI: assert property (pix_out.valid && clamp_q && $past(clamp_q, 3)
        |-> $signed(pix_out.word) <= hi) else $error("output above upper bound");
    AST_MODE_RD: assert property (bus_req.rd && bus_req.addr == A_MODE
        |=> rd_data == {31'h0, sep_q}) else $error("mode readback wrong");
    AST_CLAMP_RD: assert property (bus_req.rd && bus_req.addr == A_CLAMP
        |=> rd_data == {31'h0, clamp_q}) else $error("limit enable readback wrong");
    AST_LIM_RD: assert property (bus_req.rd && bus_req.addr[11:4] == A_VLIM_BASE[11:4]
        |=> rd_data == {8'h00, lim_q[ra_q]}) else $error("limit readback wrong");
    C_CLAMP: cover property (pix_out.valid && clamp_q);
    C_ORTHO: cover property (!sep_q && !both_g);
    C_RD: cover property (bus_req.rd ##1 rd_data != 32'h0);
endmodule
bind vfl_top vfl_top_chk i_chk (.clk(clk), .rst(rst), .bus_req(bus_req),
    .rd_data(rd_data), .pix_in(pix_in), .pix_out(pix_out));

// ---- verif/vfl_src.sv ----
// Upstream pixel source: word, set index and shift gates
module vfl_src (
    // Stimulus
    input wire logic [11:0] word,
    input wire logic [3:0] idx,
    input wire logic [1:0] gates,
    // Pixel port
    output vfl_pkg::vfl_pix_in_t pix
);
    timeunit 1ns;
    timeprecision 1ns;
    import vfl_pkg::*;
    // Set index travels beside its own word
    assign pix = '{pixel_input_word: word, vertical_set_index: idx,
        horizontal_shift_gate: gates[1], vertical_shift_gate: gates[0]};
endmodule

// ---- verif/vfl_top_bench.sv ----
// Self-checking bench for the vertical filter output path
module vfl_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import vfl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    vfl_bus_req_t bus_req = '0;
    logic [31:0] rd_data;
    vfl_pix_in_t pix_in;
    vfl_pix_out_t pix_out;
    logic [11:0] s_word = 12'h000;
    logic [3:0] s_idx = 4'h0;
    logic [1:0] s_gate = 2'b11;
    int err_count = 0;
    int samples_checked = 0;
    logic [11:0] o [8];
    logic [11:0] e [32];
    logic [11:0] d0;
    logic [11:0] ra [5] = '{A_LEN, A_STORE, A_MODE, A_CLAMP, 12'h3FF};
    always #20 clk = ~clk;
    vfl_top i_dut (.clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .pix_in(pix_in), .pix_out(pix_out));
    vfl_src i_src (.word(s_word), .idx(s_idx), .gates(s_gate), .pix(pix_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_req <= '0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        bus_req <= '0;
        #1 chk(rd_data, exp);
    endtask
    task automatic step(input logic [11:0] w, input logic [3:0] n);
        @(posedge clk);
        s_word <= w;
        s_idx <= n;
        #1;
    endtask
    // Rising ramp on set 0, last eight outputs kept
    task automatic ramp(input int n);
        for (int i = 0; i < n; i++) begin
            step(s_word + 12'h001, 4'h0);
            o[i % 8] = pix_out.word;
        end
    endtask
    // Round 3n, window shift n mod 4, bounds -16 and 16+n
    function automatic logic [11:0] model(input logic [11:0] w, input logic [3:0] n,
        input logic c);
        logic signed [31:0] acc;
        logic signed [11:0] v;
        acc = $signed(w);
        acc = acc + 3 * n;
        v = 12'(acc >>> n[1:0]);
        if (c && v < $signed(12'hFF0)) v = 12'hFF0;
        else if (c && v > $signed(12'h010 + 12'(n))) v = 12'h010 + 12'(n);
        return v;
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #800000;
        err_count++;
        complete_run();
    end
    // Test sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[k]) rdc(ra[k], 32'h0);
        wr(A_LEN, 32'h00000C00);
        rdc(A_LEN, 32'h00000C00);
        wr(A_LEN, 32'h0);
        wr(A_MODE, 32'h1);
        for (int n = 0; n < 16; n++) begin
            wr(A_VRND_BASE + 12'(n), 32'(3 * n));
            wr(A_VSEL_BASE + 12'(n), 32'(n % 4));
            wr(A_VLIM_BASE + 12'(n), {8'h00, 12'h010 + 12'(n), 12'hFF0});
        end
        rdc(A_VLIM_BASE + 12'h005, {8'h00, 12'h015, 12'hFF0});
        wr(A_COEF_BASE, 32'h1);
        ramp(80);
        $display("registers done");
        for (int p = 0; p < 2; p++) begin
            wr(A_CLAMP, 32'(p));
            for (int i = 0; i < 32; i++) begin
                step(12'(i * 167), 4'(i * 5));
                e[i] = model(12'(i * 167), 4'(i * 5), p[0]);
                if (i >= 3) chk(pix_out.word, e[i - 3]);
                if (i >= 3) chk(pix_out.valid, 1'b1);
            end
        end
        wr(A_CLAMP, 32'h0);
        $display("output stage done");
        wr(A_COEF_BASE + 12'h001, 32'h00000FFF);
        ramp(40);
        d0 = pix_out.word;
        chk(d0, 12'h004);
        wr(A_LEN, 32'h8);
        ramp(60);
        chk(12'(pix_out.word - d0), 12'h008);
        wr(A_LEN, 32'h0);
        wr(A_COEF_BASE + 12'h001, 32'h0);
        wr(A_COEF_BASE + 12'h007, 32'h00000FFF);
        wr(A_STORE, 32'h2);
        ramp(40);
        chk(pix_out.word, d0);
        $display("delay and parallel done");
        wr(A_STORE, 32'h1);
        wr(A_COEF_BASE, 32'h0);
        wr(A_COEF_BASE + 12'h007, 32'h0);
        wr(A_COEF_BASE + 12'h001, 32'h1);
        ramp(16);
        for (int i = 0; i < 4; i++) chk(o[i + 4], o[i]);
        if (o[0] === o[1]) chk(o[1], ~o[0]);
        wr(A_STORE, 32'h0);
        ramp(16);
        @(posedge clk) s_gate <= 2'b10;
        ramp(16);
        for (int i = 1; i < 8; i++) chk(o[i], o[0]);
        chk(pix_out.valid, 1'b1);
        wr(A_MODE, 32'h0);
        ramp(8);
        chk(pix_out.valid, 1'b0);
        @(posedge clk) s_gate <= 2'b11;
        ramp(8);
        chk(pix_out.valid, 1'b1);
        $display("recirculate and gating done");
        complete_run();
    end
endmodule
